// File: design/bbf_pkg.sv
// package for the boot-block flash host controller
// assumes a 40 MHz clock and an asynchronous flash device on the pins
// Summary of operation
// - chip select is active low; host drives it low to reach the device.
// - output enable is active low; host drives it low only during reads.
// - host presents program data in the second write cycle of a program sequence.
// - commands go on the low eight data lines with chip select and strobe active.
package bbf_pkg;
	localparam int        CLK_MHZ        = 40;
	// pin timing, nanoseconds
	localparam int        T_SETUP_NS     = 50;
	localparam int        T_STROBE_NS    = 75;
	localparam int        T_ACCESS_NS    = 150;
	localparam int        T_RESET_NS     = 1000;
	localparam int        T_RECOVER_NS   = 1000;
	localparam int        CYC_SETUP      = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int        CYC_STROBE     = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int        CYC_ACCESS     = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int        CYC_RESET      = (T_RESET_NS * CLK_MHZ + 999) / 1000;
	localparam int        CYC_RECOVER    = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam int        CNT_W          = 8;
	// device geometry
	localparam int        ADDR_W         = 18;
	localparam int        DATA_W         = 16;
	localparam int        BOOT_BYTES     = 16384;
	localparam int        PARAM_BYTES    = 8192;
	localparam int        MAIN_SMALL     = 98304;
	localparam int        MAIN_BIG       = 131072;
	// host register offsets
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_ADDR      = 4'h1;
	localparam logic [3:0] REG_WDATA     = 4'h2;
	localparam logic [3:0] REG_CMD       = 4'h3;
	localparam logic [3:0] REG_RDATA     = 4'h4;
	localparam logic [3:0] REG_STATUS    = 4'h5;
	// control register fields
	localparam int        CTRL_WORD      = 0;
	localparam int        CTRL_WPROT     = 1;
	localparam int        CTRL_HVRST     = 2;
	localparam int        CTRL_SIG       = 3;
	localparam int        CTRL_PD        = 4;
	localparam logic [4:0] CTRL_RESET    = 5'h01;
	// command register operations
	localparam logic [1:0] OP_READ       = 2'h0;
	localparam logic [1:0] OP_WRITE      = 2'h1;
	localparam logic [1:0] OP_PROGRAM    = 2'h2;
	localparam logic [1:0] OP_RESET      = 2'h3;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
	// status register bits from the device
	localparam int        SR_PROG_FAIL   = 4;
	localparam int        SR_ERASE_FAIL  = 5;
	typedef enum logic [1:0] {BBF_CYC_READ, BBF_CYC_WRITE} bbf_cyc_e;
endpackage : bbf_pkg

// File: design/bbf_cyc_if.sv
// carrier between the sequencer and the pin timing engine
// assumes one clock domain
`timescale 1ns/10ps
`default_nettype none
interface bbf_cyc_if;
	import bbf_pkg::*;
	logic                start;
	bbf_cyc_e            kind;
	logic [ADDR_W-1:0]   addr;
	logic                byteSel;
	logic [DATA_W-1:0]   wdata;
	logic                busy;
	logic                done;
	logic [DATA_W-1:0]   rdata;
	modport seq (output start, kind, addr, byteSel, wdata, input busy, done, rdata);
	modport eng (input start, kind, addr, byteSel, wdata, output busy, done, rdata);
endinterface : bbf_cyc_if
`default_nettype wire

// File: design/bbf_cycle.sv
// one asynchronous bus cycle on the flash pins: read or write
// assumes the sequencer waits for done before the next start
`timescale 1ns/10ps
`default_nettype none
module bbf_cycle
	import bbf_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rstn,
	input  wire logic            ce,
	input  wire logic            wordMode,
	bbf_cyc_if.eng               cyc,
	output logic [ADDR_W-1:0]    flashAddr,
	output logic                 chipSel_n,
	output logic                 outEn_n,
	output logic                 wrStrobe_n,
	input  wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0]    dataOut,
	output logic [DATA_W-1:0]    dataOe_n
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} bbf_ph_e;
	bbf_ph_e            ph, next_ph;
	logic [CNT_W-1:0]   cnt, next_cnt;
	logic               isWrite, next_isWrite;
	logic [ADDR_W-1:0]  next_flashAddr;
	logic [DATA_W-1:0]  next_dataOut, next_rdata;
	logic               next_done;

	always_comb begin
		next_ph        = ph;
		next_cnt       = cnt;
		next_isWrite   = isWrite;
		next_flashAddr = flashAddr;
		next_dataOut   = dataOut;
		next_rdata     = cyc.rdata;
		next_done      = 1'b0;
		unique case (ph)
			ST_IDLE: if (cyc.start) begin
				next_isWrite   = (cyc.kind == BBF_CYC_WRITE);
				next_flashAddr = cyc.addr;
				// in x8 the top line carries the byte select, not data
				next_dataOut   = wordMode ? cyc.wdata : {cyc.byteSel, cyc.wdata[14:0]};
				next_cnt       = CNT_W'(CYC_SETUP);
				next_ph        = ST_SETUP;
			end
			ST_SETUP: if (cnt <= CNT_W'(1)) begin
				next_cnt = isWrite ? CNT_W'(CYC_STROBE) : CNT_W'(CYC_ACCESS);
				next_ph  = ST_STROBE;
			end else begin
				next_cnt = cnt - CNT_W'(1);
			end
			ST_STROBE: if (cnt <= CNT_W'(1)) begin
				// sample before output enable is released
				if (!isWrite)
					next_rdata = wordMode ? dataIn : {8'h00, dataIn[7:0]};
				next_cnt = CNT_W'(CYC_SETUP);
				next_ph  = ST_HOLD;
			end else begin
				next_cnt = cnt - CNT_W'(1);
			end
			ST_HOLD: if (cnt <= CNT_W'(1)) begin
				next_done = 1'b1;
				next_ph   = ST_IDLE;
			end else begin
				next_cnt = cnt - CNT_W'(1);
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph        <= ST_IDLE;
			cnt       <= '0;
			isWrite   <= 1'b0;
			flashAddr <= '0;
			dataOut   <= '0;
			cyc.rdata <= '0;
			cyc.done  <= 1'b0;
		end else if (ce) begin
			ph        <= next_ph;
			cnt       <= next_cnt;
			isWrite   <= next_isWrite;
			flashAddr <= next_flashAddr;
			dataOut   <= next_dataOut;
			cyc.rdata <= next_rdata;
			cyc.done  <= next_done;
		end
	end

	assign cyc.busy = (ph != ST_IDLE);
	assign chipSel_n = (ph == ST_IDLE);
	assign outEn_n = !(ph != ST_IDLE && !isWrite);
	// strobe rises before address and data change
	assign wrStrobe_n = !(ph == ST_STROBE && isWrite);

	// top line carries byte select in x8; lines 8-14 never driven in x8
	always_comb begin
		for (int i = 0; i < DATA_W; i++) begin
			dataOe_n[i] = !(ph != ST_IDLE && isWrite);
		end
		if (!wordMode) begin
			dataOe_n[14:8] = '1;
			dataOe_n[15]   = (ph == ST_IDLE);
		end
	end
endmodule : bbf_cycle
`default_nettype wire

// File: design/bbf_host.sv
// host controller for a boot-block flash: software port to pin sequences
// assumes flash pins are asynchronous and sampled on clk; supply levels set externally
`timescale 1ns/10ps
`default_nettype none
module bbf_host
	import bbf_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rstn,
	input  wire logic            ce,
	input  wire logic [3:0]      regAddr,
	input  wire logic [31:0]     regWdata,
	input  wire logic            regWr,
	input  wire logic            regRd,
	output logic [31:0]          regRdata,
	output logic [ADDR_W-1:0]    flashAddr,
	output logic                 chipSel_n,
	output logic                 outEn_n,
	output logic                 wrStrobe_n,
	output logic                 resetPd_n,
	output logic                 resetHighVolt,
	output logic                 writeProtect_n,
	output logic                 wordSel,
	output logic                 signatureHighVolt,
	input  wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0]    dataOut,
	output logic [DATA_W-1:0]    dataOe_n
);
	typedef enum logic [2:0] {SQ_IDLE, SQ_RST, SQ_RECOVER, SQ_CYC1, SQ_CYC2, SQ_WAIT} bbf_sq_e;

	bbf_cyc_if cyc ();

	bbf_sq_e            sq, next_sq;
	logic [4:0]         ctrl, next_ctrl;
	logic [ADDR_W:0]    addrReg, next_addrReg;
	logic [DATA_W-1:0]  wdataReg, next_wdataReg;
	logic [1:0]         op, next_op;
	logic [CNT_W-1:0]   cnt, next_cnt;
	logic               opDone, next_opDone;
	logic [31:0]        next_regRdata;
	logic               start, next_start;
	bbf_cyc_e           kind, next_kind;
	logic [DATA_W-1:0]  cycData, next_cycData;
	logic               pdn, next_pdn;

	bbf_cycle u_cycle (
		.clk        (clk),
		.rstn       (rstn),
		.ce         (ce),
		.wordMode   (ctrl[CTRL_WORD]),
		.cyc        (cyc.eng),
		.flashAddr  (flashAddr),
		.chipSel_n  (chipSel_n),
		.outEn_n    (outEn_n),
		.wrStrobe_n (wrStrobe_n),
		.dataIn     (dataIn),
		.dataOut    (dataOut),
		.dataOe_n   (dataOe_n)
	);

	assign cyc.start   = start;
	assign cyc.kind    = kind;
	assign cyc.addr    = addrReg[ADDR_W:1];
	assign cyc.byteSel = addrReg[0];
	assign cyc.wdata   = ctrl[CTRL_WORD] ? cycData : {8'h00, cycData[7:0]};

	assign wordSel           = ctrl[CTRL_WORD];
	assign writeProtect_n    = ctrl[CTRL_WPROT];
	assign resetHighVolt     = ctrl[CTRL_HVRST] & pdn;
	assign signatureHighVolt = ctrl[CTRL_SIG];
	// reset pin low during reset pulse or power-down
	assign resetPd_n         = pdn;

	always_comb begin
		next_sq       = sq;
		next_ctrl     = ctrl;
		next_addrReg  = addrReg;
		next_wdataReg = wdataReg;
		next_op       = op;
		next_cnt      = cnt;
		next_opDone   = opDone;
		next_start    = 1'b0;
		next_kind     = kind;
		next_cycData  = cycData;
		next_pdn      = pdn;
		next_regRdata = 32'h0000_0000;
		if (regRd) begin
			unique case (regAddr)
				REG_CTRL:   next_regRdata = {27'h0, ctrl};
				REG_ADDR:   next_regRdata = {13'h0, addrReg};
				REG_WDATA:  next_regRdata = {16'h0, wdataReg};
				REG_RDATA:  next_regRdata = {16'h0, cyc.rdata};
				REG_STATUS: next_regRdata = {29'h0, !pdn, opDone, (sq != SQ_IDLE)};
				default:    next_regRdata = 32'h0000_0000;
			endcase
		end
		if (regWr) begin
			unique case (regAddr)
				REG_CTRL:  next_ctrl     = regWdata[4:0];
				REG_ADDR:  next_addrReg  = regWdata[ADDR_W:0];
				REG_WDATA: next_wdataReg = regWdata[DATA_W-1:0];
				default: ;
			endcase
		end
		// a new command is taken only in SQ_IDLE, so its clear never lands together with a completion
		if (regWr && regAddr == REG_CMD && sq == SQ_IDLE) begin
			next_op     = regWdata[1:0];
			next_opDone = 1'b0;
			unique case (regWdata[1:0])
				OP_RESET: begin
					next_pdn = 1'b0;
					next_cnt = CNT_W'(CYC_RESET);
					next_sq  = SQ_RST;
				end
				OP_PROGRAM: begin
					next_cycData = {8'h00, CMD_PROG_SETUP};
					next_kind    = BBF_CYC_WRITE;
					next_start   = pdn;
					next_sq      = pdn ? SQ_CYC1 : SQ_IDLE;
				end
				default: begin
					next_cycData = next_wdataReg;
					next_kind    = (regWdata[1:0] == OP_WRITE) ? BBF_CYC_WRITE : BBF_CYC_READ;
					next_start   = pdn;
					next_sq      = pdn ? SQ_WAIT : SQ_IDLE;
				end
			endcase
		end
		if (regWr && regAddr == REG_CTRL) begin
			// power-down holds the reset pin low until cleared or until a reset command's pulse ends
			next_pdn = !regWdata[CTRL_PD];
		end
		unique case (sq)
			SQ_IDLE: ;
			SQ_RST: if (cnt <= CNT_W'(1)) begin
				next_pdn = 1'b1;
				next_cnt = CNT_W'(CYC_RECOVER);
				next_sq  = SQ_RECOVER;
			end else begin
				next_cnt = cnt - CNT_W'(1);
			end
			// device is in array read after recovery
			SQ_RECOVER: if (cnt <= CNT_W'(1)) begin
				next_opDone = 1'b1;
				next_sq     = SQ_IDLE;
			end else begin
				next_cnt = cnt - CNT_W'(1);
			end
			// program data on second write cycle
			SQ_CYC1: if (cyc.done) begin
				next_cycData = wdataReg;
				next_start   = 1'b1;
				next_sq      = SQ_WAIT;
			end
			SQ_WAIT: if (cyc.done) begin
				next_opDone = 1'b1;
				next_sq     = SQ_IDLE;
			end
			default: next_sq = SQ_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sq       <= SQ_IDLE;
			ctrl     <= CTRL_RESET;
			addrReg  <= '0;
			wdataReg <= '0;
			op       <= OP_READ;
			cnt      <= '0;
			opDone   <= 1'b0;
			regRdata <= 32'h0000_0000;
			start    <= 1'b0;
			kind     <= BBF_CYC_READ;
			cycData  <= '0;
			pdn      <= 1'b1;
		end else if (ce) begin
			sq       <= next_sq;
			ctrl     <= next_ctrl;
			addrReg  <= next_addrReg;
			wdataReg <= next_wdataReg;
			op       <= next_op;
			cnt      <= next_cnt;
			opDone   <= next_opDone;
			regRdata <= next_regRdata;
			start    <= next_start;
			kind     <= next_kind;
			cycData  <= next_cycData;
			pdn      <= next_pdn;
		end
	end
endmodule : bbf_host
`default_nettype wire

// File: verif/bbf_host_chk.sv
// pin-level assertions for bbf_host
// assumes the bind below reaches every bbf_host instance
`timescale 1ns/10ps
`default_nettype none
module bbf_host_chk
	import bbf_pkg::*;
(
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic [ADDR_W-1:0] flashAddr,
	input wire logic              chipSel_n,
	input wire logic              outEn_n,
	input wire logic              wrStrobe_n,
	input wire logic              resetPd_n,
	input wire logic              wordSel,
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic [DATA_W-1:0] dataOe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_oe_needs_cs: assert property (!outEn_n |-> !chipSel_n)
		else $error("output enable without select");
	a_wr_needs_cs: assert property (!wrStrobe_n |-> !chipSel_n)
		else $error("strobe without select");
	a_rd_wr_apart: assert property (!(!outEn_n && !wrStrobe_n))
		else $error("read and write at once");
	a_drive_not_read: assert property ((!(&dataOe_n[14:0]) || (wordSel && !dataOe_n[15])) |-> outEn_n)
		else $error("host drives during read");
	a_byte_lines_off: assert property (!wordSel |-> &dataOe_n[14:8])
		else $error("middle data lines driven in x8");
	a_byte_sel_driven: assert property ((!wordSel && !chipSel_n) |-> !dataOe_n[15])
		else $error("byte select line not driven in x8");
	a_latch_stable: assert property ($past(!wrStrobe_n) |-> $stable(flashAddr) && $stable(dataOut))
		else $error("address or data moved under strobe");
	a_strobe_len: assert property ($fell(wrStrobe_n) |-> !wrStrobe_n[*3] ##1 wrStrobe_n)
		else $error("strobe width wrong");
	a_pd_quiet: assert property (!resetPd_n |-> chipSel_n && outEn_n && wrStrobe_n && &dataOe_n)
		else $error("pins active in power-down");
	a_recover_hold: assert property ($rose(resetPd_n) |-> chipSel_n[*8])
		else $error("access too soon after reset");
endmodule : bbf_host_chk
bind bbf_host bbf_host_chk chk (.clk(clk), .rstn(rstn), .flashAddr(flashAddr), .chipSel_n(chipSel_n),
	.outEn_n(outEn_n), .wrStrobe_n(wrStrobe_n), .resetPd_n(resetPd_n), .wordSel(wordSel), .dataOut(dataOut),
	.dataOe_n(dataOe_n));
`default_nettype wire

// File: verif/bbf_flash_model.sv
// behavioural top-boot flash on the host pins
// assumes the bench resolves the data bus; x8 programming is not modelled
`timescale 1ns/10ps
`default_nettype none
module bbf_flash_model
	import bbf_pkg::*;
#(
	// arbitrary identifier values
	parameter logic [15:0] MFR_CODE = 16'h00a5,
	parameter logic [15:0] DEV_CODE = 16'h005c
)(
	input  wire logic [ADDR_W-1:0] flashAddr,
	input  wire logic              chipSel_n,
	input  wire logic              outEn_n,
	input  wire logic              wrStrobe_n,
	input  wire logic              resetPd_n,
	input  wire logic              resetHighVolt,
	input  wire logic              writeProtect_n,
	input  wire logic              wordSel,
	input  wire logic              signatureHighVolt,
	input  wire logic              supplyLow,
	input  wire logic [DATA_W-1:0] dq,
	output logic [DATA_W-1:0]      devDq
);
	logic [15:0] mem [logic [17:0]];
	logic [1:0]  mode = 2'd0;
	logic        armed = 1'b0;
	logic [7:0]  stat = 8'h80;
	logic [15:0] val, mask;
	logic [15:0] hold = 16'h0000;
	always_comb begin
		val = mem.exists(flashAddr) ? mem[flashAddr] : 16'hffff;
		// top data line picks the byte
		if (!wordSel && dq[15])
			val = val >> 8;
		if (mode == 2'd1)
			val = {8'h00, stat};
		// identifier codes by address bit 0
		if (signatureHighVolt || mode == 2'd2)
			val = flashAddr[0] ? DEV_CODE : MFR_CODE;
	end
	// drive only when awake, selected and enabled
	assign mask = (!chipSel_n && !outEn_n && resetPd_n) ? (wordSel ? 16'hffff : 16'h00ff) : 16'h0000;
	always @* if (mask[0]) hold = val;
	// released lines show the inverse of the last value, never a stale copy
	assign devDq = (val & mask) | (~hold & ~mask);
	always @(posedge wrStrobe_n) if (!chipSel_n && resetPd_n) begin
		if (armed) begin
			armed = 1'b0;
			mode = 2'd1;
			// low program supply locks every block
			if (supplyLow)
				stat[3] = 1'b1;
			// boot block lock; blocks below it stay writable
			else if (flashAddr >= 18'h3e000 && !writeProtect_n && !resetHighVolt)
				stat[4] = 1'b1;
			else if (wordSel)
				mem[flashAddr] = (mem.exists(flashAddr) ? mem[flashAddr] : 16'hffff) & dq;
		end else case (dq[7:0])
			8'h40, 8'h10: armed = 1'b1;
			8'h70: mode = 2'd1;
			8'h90: mode = 2'd2;
			8'h50: stat = 8'h80;
			default: mode = 2'd0;
		endcase
	end
	// reset clears the state machine and returns to array reads
	always @(negedge resetPd_n) begin
		mode = 2'd0;
		armed = 1'b0;
		stat = 8'h80;
	end
endmodule : bbf_flash_model
`default_nettype wire

// File: verif/bbf_host_tb.sv
// self-checking bench: bbf_host driving a flash model
// assumes package, checker and model compiled first
`timescale 1ns/10ps
`default_nettype none
module bbf_host_tb;
	import bbf_pkg::*;
	// arbitrary identifier codes
	localparam logic [15:0] MFR = 16'h3ca5;
	localparam logic [15:0] DEV = 16'h4e5c;
	logic                   clk = 1'b0;
	logic                   rstn = 1'b0;
	logic                   ce = 1'b1;
	logic [3:0]             regAddr = 4'h0;
	logic [31:0]            regWdata = 32'h0;
	logic                   regWr = 1'b0;
	logic                   regRd = 1'b0;
	logic                   supplyLow = 1'b0;
	logic [31:0]            regRdata, rv;
	logic [ADDR_W-1:0]      flashAddr;
	logic                   chipSel_n, outEn_n, wrStrobe_n, resetPd_n;
	logic                   resetHighVolt, writeProtect_n, wordSel, signatureHighVolt;
	logic [DATA_W-1:0]      dataOut, dataOe_n, devDq, code;
	wire logic [DATA_W-1:0] dq;
	int                     fail_count = 0;
	int                     checks = 0;
	logic [31:0]            seed = 32'd44931;
	logic [17:0]            adr [8];
	logic [15:0]            dat [8];
	assign dq = (dataOut & ~dataOe_n) | (devDq & dataOe_n);
	bbf_host uut (.clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr), .chipSel_n(chipSel_n), .outEn_n(outEn_n),
		.wrStrobe_n(wrStrobe_n), .resetPd_n(resetPd_n), .resetHighVolt(resetHighVolt),
		.writeProtect_n(writeProtect_n), .wordSel(wordSel), .signatureHighVolt(signatureHighVolt),
		.dataIn(dq), .dataOut(dataOut), .dataOe_n(dataOe_n));
	bbf_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.flashAddr(flashAddr), .chipSel_n(chipSel_n),
		.outEn_n(outEn_n), .wrStrobe_n(wrStrobe_n), .resetPd_n(resetPd_n), .resetHighVolt(resetHighVolt),
		.writeProtect_n(writeProtect_n), .wordSel(wordSel), .signatureHighVolt(signatureHighVolt),
		.supplyLow(supplyLow), .dq(dq), .devDq(devDq));
	initial forever #12.5 clk = ~clk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask : rd
	// one operation, polled for done under a bound
	task automatic op(input logic [1:0] o, input logic [18:0] a, input logic [15:0] d);
		wr(REG_ADDR, {13'h0, a});
		wr(REG_WDATA, {16'h0, d});
		wr(REG_CMD, {30'h0, o});
		for (int i = 0; i < 100; i++) begin
			rd(REG_STATUS, rv);
			if (rv[1:0] === 2'b10)
				break;
		end
		chk("done", rv[1:0], 2'b10);
	endtask : op
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd(REG_CTRL, rv);
		chk("ctrl", rv, {27'h0, CTRL_RESET});
		rd(4'hf, rv);
		chk("unmapped", rv, 32'h0);
		for (int i = 0; i < 8; i++) begin
			rv = xs();
			adr[i] = {i[2:0], 5'h0, rv[9:0]};
			dat[i] = rv[31:16];
			op(OP_PROGRAM, {adr[i], 1'b0}, dat[i]);
		end
		op(OP_WRITE, 19'h0, 16'h00ff);
		for (int i = 0; i < 10; i++) begin
			wr(REG_CTRL, {31'h0, i < 8});
			op(OP_READ, {adr[i % 8], i[0]}, 16'h0);
			rd(REG_RDATA, rv);
			if (i < 8)
				chk("word", rv[15:0], dat[i]);
			else
				chk("byte", rv[7:0], i[0] ? dat[i % 8][15:8] : dat[i % 8][7:0]);
		end
		for (int m = 0; m < 4; m++) begin
			wr(REG_CTRL, {28'h0, 1'b1, 2'b00, m[1]});
			op(OP_READ, {17'h0, m[0], 1'b1}, 16'h0);
			rd(REG_RDATA, rv);
			code = m[0] ? DEV : MFR;
			chk("signature", m[1] ? rv[15:0] : {8'h0, rv[7:0]}, m[1] ? code : {8'h0, code[7:0]});
		end
		for (int m = 0; m < 3; m++) begin
			wr(REG_CTRL, m == 0 ? 32'h1 : (m == 1 ? 32'h3 : 32'h5));
			op(OP_PROGRAM, {18'h3e000 + 18'(m), 1'b0}, 16'h1234);
			op(OP_READ, 19'h0, 16'h0);
			rd(REG_RDATA, rv);
			chk("refusal flag", rv[4], m == 0);
			op(OP_WRITE, 19'h0, 16'h0050);
			op(OP_WRITE, 19'h0, 16'h00ff);
			op(OP_READ, {18'h3e000 + 18'(m), 1'b0}, 16'h0);
			rd(REG_RDATA, rv);
			chk("boot word", rv[15:0], m == 0 ? 16'hffff : 16'h1234);
		end
		wr(REG_CTRL, 32'h1);
		op(OP_PROGRAM, {18'h3dfff, 1'b0}, 16'h0f0f);
		op(OP_WRITE, 19'h0, 16'h00ff);
		op(OP_READ, {18'h3dfff, 1'b0}, 16'h0);
		rd(REG_RDATA, rv);
		chk("param word", rv[15:0], 16'h0f0f);
		supplyLow <= 1'b1;
		op(OP_PROGRAM, {adr[2], 1'b0}, 16'h0000);
		op(OP_WRITE, 19'h0, 16'h0090);
		op(OP_READ, 19'h0, 16'h0);
		rd(REG_RDATA, rv);
		chk("lockout id", rv[15:0], MFR);
		op(OP_WRITE, 19'h0, 16'h00ff);
		op(OP_READ, {adr[2], 1'b0}, 16'h0);
		rd(REG_RDATA, rv);
		chk("lockout word", rv[15:0], dat[2]);
		supplyLow <= 1'b0;
		op(OP_PROGRAM, {adr[1], 1'b0}, dat[1]);
		op(OP_RESET, 19'h0, 16'h0);
		op(OP_READ, {adr[1], 1'b0}, 16'h0);
		rd(REG_RDATA, rv);
		chk("after reset", rv[15:0], dat[1]);
		summarize();
	end
endmodule : bbf_host_tb
`default_nettype wire
